// >>> design/lock_regs.sv
// Identity, revision and lock test register bank with APB slave
`timescale 1ns/1ps
`default_nettype none

module lock_regs
#(
    parameter logic [7:0] IDENT_LOW = 8'h5a,    // Arbitrary value
    parameter logic [7:0] IDENT_HIGH = 8'ha5,   // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01,     // Arbitrary value
    parameter int unsigned WINDOW_LEN = lock_regs_pkg::WINDOW_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [lock_regs_pkg::APB_AW-1:0] paddr_i,
    input wire logic [lock_regs_pkg::APB_DW-1:0] pwdata_i,
    output logic [lock_regs_pkg::APB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Tracking loop side
    input wire logic loop_phase_lost_i,
    input wire logic new_reference_i,
    output lock_regs_pkg::capture_mode_t capture_mode_o,
    output logic divider_resync_o,
    output logic frame_edge_sense_o,
    output logic irq_o
);
    import lock_regs_pkg::*;

    // ==========================================================
    // Reset release and window timers
    // ==========================================================
    logic rst_n;                                // Synchronised reset
    logic cap_active;                           // Nearest-edge window open
    logic cap_expired;                          // Window just closed
    logic pwr_active;                           // Power-up resync window open

    reset_release u_rst (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .resetn_o(rst_n)
    );

    // Capture window restarts on every reference change
    window_timer #(.CYCLES(WINDOW_LEN), .START_ACTIVE(1'b0)) u_cap (
        .clk_i(clk_i),
        .resetn_i(rst_n),
        .start_i(new_reference_i),
        .active_o(cap_active),
        .expired_o(cap_expired)
    );

    // Resync window runs once from power-up and never restarts
    window_timer #(.CYCLES(WINDOW_LEN), .START_ACTIVE(1'b1)) u_pwr (
        .clk_i(clk_i),
        .resetn_i(rst_n),
        .start_i(1'b0),
        .active_o(pwr_active),
        .expired_o()
    );

    // ==========================================================
    // Block state
    // ==========================================================
    typedef struct packed {
        logic [REG_W-1:0] ctrl;                 // Stored control bits
        logic lost;                             // Last loop status
        logic [INT_W-1:0] status;               // Sticky events
        logic [INT_W-1:0] mask;                 // Interrupt enables
        logic [APB_DW-1:0] rdata;
        logic ready;
        logic err;
        capture_mode_t mode;
        logic resync;
        logic irq;
    } state_t;

    state_t st;
    state_t next_st;

    // Index decode: word aligned and in range
    function automatic logic addr_ok(input logic [APB_AW-1:0] a);
        addr_ok = (a[1:0] == 2'h0) && ((a >> ADDR_SHIFT) <= IDX_INT_MASK);
    endfunction : addr_ok

    function automatic logic [APB_AW-1:0] addr_idx(input logic [APB_AW-1:0] a);
        addr_idx = a >> ADDR_SHIFT;
    endfunction : addr_idx

    // ==========================================================
    // Next-state logic
    // ==========================================================
    logic setup;                                // APB setup cycle
    logic wr_take;                              // Write committing this edge
    logic [INT_W-1:0] events;                   // Event pulses
    logic [INT_W-1:0] w1c;                      // Software clear bits
    logic [REG_W-1:0] rd_byte;                  // Byte being read

    always_comb
    begin
        next_st = st;
        setup = psel_i && !penable_i;
        wr_take = psel_i && penable_i && st.ready && pwrite_i && !st.err;
        events = '0;
        w1c = '0;
        rd_byte = '0;

        // Loop status edges and window end become events
        events[INT_LOCK_LOST] = loop_phase_lost_i && !st.lost;
        events[INT_LOCK_GAINED] = !loop_phase_lost_i && st.lost;
        events[INT_WINDOW_END] = cap_expired;
        next_st.lost = loop_phase_lost_i;

        // Register writes; identity and revision ignore writes
        if (wr_take)
        begin
            case (addr_idx(paddr_i))
                IDX_LOCK_CTRL:
                    next_st.ctrl = pwdata_i[REG_W-1:0] & CTRL_WMASK;
                IDX_INT_STATUS:
                    w1c = pwdata_i[INT_W-1:0];
                IDX_INT_MASK:
                    next_st.mask = pwdata_i[INT_W-1:0];
                default:
                    next_st.ctrl = st.ctrl;
            endcase
        end

        // Set wins over a same-cycle clear
        next_st.status = (st.status & ~w1c) | events;

        // Read mux; bit 7 is live loop status, bit 5 reads zero
        case (addr_idx(paddr_i))
            IDX_IDENT_LOW: rd_byte = IDENT_LOW;
            IDX_IDENT_HIGH: rd_byte = IDENT_HIGH;
            IDX_REVISION: rd_byte = REVISION;
            IDX_LOCK_CTRL:
            begin
                rd_byte = st.ctrl;
                rd_byte[BIT_PHASE_LOST] = st.lost;
                rd_byte[BIT_UNUSED] = 1'b0;
            end
            IDX_INT_STATUS: rd_byte = REG_W'(st.status);
            IDX_INT_MASK: rd_byte = REG_W'(st.mask);
            default: rd_byte = '0;
        endcase

        // Answer one cycle after setup: zero wait states
        next_st.ready = setup;
        next_st.err = setup && !addr_ok(paddr_i);
        if (setup && !pwrite_i && addr_ok(paddr_i))
            next_st.rdata = APB_DW'(rd_byte);
        else if (setup)
            next_st.rdata = '0;

        // Capture mode for the tracking loop
        if (st.ctrl[BIT_FORCE_FREQ])
            next_st.mode = CAP_FREQ;
        else if (cap_active)
            next_st.mode = CAP_NEAREST;
        else
            next_st.mode = CAP_WIDE;

        // Divider resync: bit 4 clear limits it to power-up window
        next_st.resync = st.ctrl[BIT_RESYNC_ANY] || pwr_active;

        // Level interrupt while any unmasked event is pending
        next_st.irq = |(next_st.status & st.mask);
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st.ctrl <= CTRL_RESET;
            st.lost <= 1'b0;
            st.status <= '0;
            st.mask <= INT_MASK_RESET;
            st.rdata <= '0;
            st.ready <= 1'b0;
            st.err <= 1'b0;
            st.mode <= CAP_WIDE;
            st.resync <= 1'b1;
            st.irq <= 1'b0;
        end
        else
            st <= next_st;
    end

    // Outputs straight from the state flops
    assign prdata_o = st.rdata;
    assign pready_o = st.ready;
    assign pslverr_o = st.err;
    assign capture_mode_o = st.mode;
    assign divider_resync_o = st.resync;
    assign frame_edge_sense_o = st.ctrl[BIT_EDGE_SENSE];
    assign irq_o = st.irq;

    // ==========================================================
    // Assertions
    // ==========================================================
    localparam logic [APB_AW-1:0] A_LOW = IDX_IDENT_LOW << ADDR_SHIFT;
    localparam logic [APB_AW-1:0] A_HIGH = IDX_IDENT_HIGH << ADDR_SHIFT;
    localparam logic [APB_AW-1:0] A_CTRL = IDX_LOCK_CTRL << ADDR_SHIFT;

    // Identity bytes read as constants whatever was written
    AST_IDENT_READ: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (setup && !pwrite_i && (paddr_i == A_LOW || paddr_i == A_HIGH))
        |=> pready_o && prdata_o[REG_W-1:0] ==
            ((paddr_i == A_HIGH) ? IDENT_HIGH : IDENT_LOW))
        else $error("identity byte read wrong");

    // Bit 7 tracks loop status seen in setup cycle
    AST_LOCK_BIT: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (setup && !pwrite_i && paddr_i == A_CTRL)
        |=> prdata_o[BIT_PHASE_LOST] == $past(st.lost) && !prdata_o[BIT_UNUSED])
        else $error("phase status bit wrong");

    // New reference opens nearest-edge capture two edges later
    AST_NEAREST: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (new_reference_i && !st.ctrl[BIT_FORCE_FREQ] && !wr_take)
        |-> ##2 capture_mode_o == CAP_NEAREST)
        else $error("nearest capture not entered");

    // Window end reverts to wide capture
    AST_WIDEN: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (cap_expired && !new_reference_i && !st.ctrl[BIT_FORCE_FREQ] && !wr_take)
        |=> capture_mode_o == CAP_WIDE)
        else $error("capture range did not widen");

    // Forced frequency lock overrides the window
    AST_FORCE: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        st.ctrl[BIT_FORCE_FREQ] |=> capture_mode_o == CAP_FREQ)
        else $error("frequency lock not forced");

    // Resync off once power-up window over and bit 4 clear
    AST_RESYNC: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (!st.ctrl[BIT_RESYNC_ANY] && !pwr_active) |=> !divider_resync_o)
        else $error("divider resync outside window");

    // Interrupt follows masked status
    AST_IRQ: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        ##1 irq_o == |($past(next_st.status) & $past(st.mask)))
        else $error("interrupt level wrong");

    // Every setup gets exactly one ready cycle, no wait states
    AST_READY: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        setup |=> pready_o ##1 !pready_o)
        else $error("ready not a single cycle");

    // Bad address answers with an error and zero data
    AST_BAD_ADDR: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (setup && !addr_ok(paddr_i)) |=> pready_o && pslverr_o && prdata_o == '0)
        else $error("bad address not refused");

    // A good address never reports an error
    AST_GOOD_ADDR: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (setup && addr_ok(paddr_i)) |=> pready_o && !pslverr_o)
        else $error("good address refused");

    // Lock-lost event stays pending until software clears it
    AST_STICKY: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        (st.status[INT_LOCK_LOST] && !w1c[INT_LOCK_LOST]) |=> st.status[INT_LOCK_LOST])
        else $error("pending event lost");

    // Power-up window always allows divider resync
    AST_RESYNC_WINDOW: assert property (
        @(posedge clk_i) disable iff (!rst_n)
        pwr_active |=> divider_resync_o)
        else $error("resync blocked in power-up window");

    COV_READ_LOST: cover property (
        @(posedge clk_i) disable iff (!rst_n)
        pready_o && st.lost && prdata_o[BIT_PHASE_LOST]);
    COV_NEAREST: cover property (
        @(posedge clk_i) disable iff (!rst_n)
        capture_mode_o == CAP_NEAREST ##1 capture_mode_o == CAP_WIDE);
    COV_IRQ: cover property (
        @(posedge clk_i) disable iff (!rst_n) $rose(irq_o));
    COV_FORCE_RELEASE: cover property (
        @(posedge clk_i) disable iff (!rst_n)
        capture_mode_o == CAP_FREQ ##1 capture_mode_o == CAP_NEAREST);

endmodule : lock_regs
`default_nettype wire

// >>> design/lock_regs_pkg.sv
// Constants shared by the identity and lock-test register bank
package lock_regs_pkg;

    // ==========================================================
    // Bus geometry
    // ==========================================================
    localparam int APB_AW = 8;                  // APB address width
    localparam int APB_DW = 32;                 // APB data width
    localparam int REG_W = 8;                   // Register width

    // ==========================================================
    // Register indices and byte addresses (byte = 4 x index)
    // ==========================================================
    localparam logic [APB_AW-1:0] IDX_IDENT_LOW = 8'h00;
    localparam logic [APB_AW-1:0] IDX_IDENT_HIGH = 8'h01;
    localparam logic [APB_AW-1:0] IDX_REVISION = 8'h02;
    localparam logic [APB_AW-1:0] IDX_LOCK_CTRL = 8'h03;
    localparam logic [APB_AW-1:0] IDX_INT_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] IDX_INT_MASK = 8'h05;
    localparam logic [1:0] ADDR_SHIFT = 2'h2;   // Word-aligned registers

    // ==========================================================
    // Lock test and control register layout
    // ==========================================================
    localparam int BIT_PHASE_LOST = 7;          // Read-only loop status
    localparam int BIT_FORCE_FREQ = 6;          // Disable nearest-edge capture
    localparam int BIT_UNUSED = 5;              // Reads zero
    localparam int BIT_RESYNC_ANY = 4;          // Divider resync control
    localparam int BIT_EDGE_SENSE = 2;          // Stored, drives frame_edge_sense_o
    localparam logic [REG_W-1:0] CTRL_RESET = 8'h14;
    localparam logic [REG_W-1:0] CTRL_WMASK = 8'h5f;  // Bits 7 and 5 not stored

    // ==========================================================
    // Interrupt status layout
    // ==========================================================
    localparam int INT_W = 3;
    localparam int INT_LOCK_LOST = 0;           // Loop went phase lost
    localparam int INT_LOCK_GAINED = 1;         // Loop regained phase lock
    localparam int INT_WINDOW_END = 2;          // Nearest-edge window expired
    localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam longint CLK_HZ = 20_000_000;     // Clock rate in Hz
    localparam longint WINDOW_S = 2;            // Capture and resync window, s
    localparam int WINDOW_CYCLES = int'(WINDOW_S * CLK_HZ);

    // ==========================================================
    // Capture mode handed to the tracking loop (Gray along path)
    // ==========================================================
    typedef enum logic [1:0] {
        CAP_WIDE = 2'h0,                        // Capture range +-360 deg
        CAP_NEAREST = 2'h1,                     // Nearest edge within +-180 deg
        CAP_FREQ = 2'h3                         // Forced frequency lock
    } capture_mode_t;

endpackage : lock_regs_pkg

// >>> design/reset_release.sv
// Two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
`default_nettype none

module reset_release (
    input wire logic clk_i,
    input wire logic resetn_i,
    output logic resetn_o
);

    // ==========================================================
    // Synchroniser state
    // ==========================================================
    typedef struct packed {
        logic first;                            // Read only by second stage
        logic second;
    } rel_t;

    rel_t st;
    rel_t next_st;

    // Shift a one in; assertion is immediate, release takes two edges
    always_comb
    begin
        next_st.first = 1'b1;
        next_st.second = st.first;
    end

    // Both stages clear asynchronously to constants
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign resetn_o = st.second;

endmodule : reset_release
`default_nettype wire

// >>> design/window_timer.sv
// One-shot window timer: active for a set number of cycles after a start
`timescale 1ns/1ps
`default_nettype none

module window_timer #(
    parameter int unsigned CYCLES = 40_000_000,
    parameter bit START_ACTIVE = 1'b0
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    output logic active_o,
    output logic expired_o
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    // ==========================================================
    // Timer state
    // ==========================================================
    typedef struct packed {
        logic [CW-1:0] count;                   // Cycles left in window
        logic active;
        logic expired;                          // One-cycle end pulse
    } tmr_t;

    tmr_t st;
    tmr_t next_st;

    // A start always reloads, so a new reference restarts the window
    always_comb
    begin
        next_st = st;
        next_st.expired = 1'b0;
        if (start_i)
        begin
            next_st.count = LOAD;
            next_st.active = 1'b1;
        end
        else if (st.active)
        begin
            if (st.count <= CW'(1))
            begin
                next_st.count = '0;
                next_st.active = 1'b0;
                next_st.expired = 1'b1;
            end
            else
                next_st.count = st.count - CW'(1);
        end
    end

    // Power-up windows start running straight out of reset
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st.count <= START_ACTIVE ? LOAD : '0;
            st.active <= START_ACTIVE;
            st.expired <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign active_o = st.active;
    assign expired_o = st.expired;

endmodule : window_timer
`default_nettype wire

// >>> tb/lock_regs_test.sv
// Self-checking bench for the identity and lock-test register bank
`timescale 1ns/1ps
`default_nettype none

// Compare a design value to its expected value and count the outcome
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
        end \
    end

module lock_regs_test;
    import lock_regs_pkg::*;

    // ==========================================================
    // Signals
    // ==========================================================
    localparam int unsigned WLEN = 20;          // Short window keeps the run brief
    localparam logic [APB_AW-1:0] A_LOW = IDX_IDENT_LOW << ADDR_SHIFT;
    localparam logic [APB_AW-1:0] A_HIGH = IDX_IDENT_HIGH << ADDR_SHIFT;
    localparam logic [APB_AW-1:0] A_REV = IDX_REVISION << ADDR_SHIFT;
    localparam logic [APB_AW-1:0] A_CTRL = IDX_LOCK_CTRL << ADDR_SHIFT;
    localparam logic [APB_AW-1:0] A_STAT = IDX_INT_STATUS << ADDR_SHIFT;
    localparam logic [APB_AW-1:0] A_MASK = IDX_INT_MASK << ADDR_SHIFT;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;                      // Held low from time zero
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [APB_AW-1:0] paddr_i = '0;
    logic [APB_DW-1:0] pwdata_i = '0;
    logic loop_phase_lost_i = 1'b0;
    logic new_reference_i = 1'b0;
    logic [APB_DW-1:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    capture_mode_t capture_mode_o;
    logic divider_resync_o;
    logic frame_edge_sense_o;
    logic irq_o;
    logic [APB_DW-1:0] rdata;                   // Data taken at the access edge
    logic err;                                  // Error taken at the access edge
    int fails = 0;
    int samples_checked = 0;

    // 20 MHz clock
    always #25 clk_i = ~clk_i;

    lock_regs #(.WINDOW_LEN(WLEN)) uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .loop_phase_lost_i(loop_phase_lost_i),
        .new_reference_i(new_reference_i), .capture_mode_o(capture_mode_o),
        .divider_resync_o(divider_resync_o), .frame_edge_sense_o(frame_edge_sense_o),
        .irq_o(irq_o)
    );

    // ==========================================================
    // Tasks
    // ==========================================================
    // Verdict and the single end of the run
    task end_of_test;
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // One APB transfer; request held until pready is seen at an edge
    task apb(input logic wr, input logic [APB_AW-1:0] addr, input logic [APB_DW-1:0] wd);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        rdata = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        // A slave that never answers ends the run
        if (pready_o !== 1'b1)
        begin
            fails++;
            end_of_test();
        end
    endtask : apb

    // Read a byte register and expect a clean answer
    task rd(input logic [APB_AW-1:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, '0);
        `CHK(rdata, {24'h0, exp})
        `CHK(err, 1'b0)
    endtask : rd

    // Write a byte register and expect a clean answer
    task wr(input logic [APB_AW-1:0] addr, input logic [7:0] data);
        apb(1'b1, addr, {24'h0, data});
        `CHK(err, 1'b0)
    endtask : wr

    // Wait a bounded number of edges for a capture mode
    task wait_mode(input capture_mode_t m, input int lim);
        int n;
        n = 0;
        while (capture_mode_o !== m && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
        `CHK(capture_mode_o, m)
    endtask : wait_mode

    // One-cycle reference change pulse
    task new_ref;
        @(posedge clk_i);
        new_reference_i <= 1'b1;
        @(posedge clk_i);
        new_reference_i <= 1'b0;
    endtask : new_ref

    // ==========================================================
    // Watchdog: a hang counts as a mismatch
    // ==========================================================
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        repeat (10) @(posedge clk_i);
        // Outputs while reset is held
        `CHK(capture_mode_o, CAP_WIDE)
        `CHK(divider_resync_o, 1'b1)
        `CHK(irq_o, 1'b0)
        resetn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        // Clearing bit 4 early: resync stays allowed only inside the power-up window
        wr(A_CTRL, 8'h04);
        repeat (3) @(posedge clk_i);
        `CHK(divider_resync_o, 1'b1)
        repeat (20) @(posedge clk_i);
        `CHK(divider_resync_o, 1'b0)
        wr(A_CTRL, CTRL_RESET);
        repeat (3) @(posedge clk_i);
        `CHK(divider_resync_o, 1'b1)
        `CHK(frame_edge_sense_o, 1'b1)
        // Identity and revision are read-only; identity writes leave both bytes unchanged
        rd(A_LOW, 8'h5a);
        rd(A_HIGH, 8'ha5);
        rd(A_REV, 8'h01);
        wr(A_LOW, 8'h00);
        wr(A_HIGH, 8'hff);
        rd(A_LOW, 8'h5a);
        rd(A_HIGH, 8'ha5);
        rd(A_CTRL, CTRL_RESET);
        // Unmapped and unaligned places answer with an error and zero data
        apb(1'b0, 8'h18, '0);
        `CHK({err, rdata}, {1'b1, 32'h0})
        apb(1'b1, 8'h0d, 32'h0);
        `CHK(err, 1'b1)
        // Phase lost shows in bit 7 and raises the lock-lost event
        wr(A_STAT, 8'h07);
        wr(A_MASK, 8'h01);
        loop_phase_lost_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        rd(A_CTRL, 8'h94);
        rd(A_STAT, 8'h01);
        wr(A_MASK, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        wr(A_MASK, 8'h01);
        wr(A_STAT, 8'h01);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        loop_phase_lost_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(A_CTRL, CTRL_RESET);
        rd(A_STAT, 8'h02);
        wr(A_STAT, 8'h07);
        // New reference: nearest-edge capture for the window, then wide range
        new_ref();
        wait_mode(CAP_NEAREST, 4);
        repeat (12) @(posedge clk_i);
        `CHK(capture_mode_o, CAP_NEAREST)
        wait_mode(CAP_WIDE, 16);
        rd(A_STAT, 8'h04);
        wr(A_STAT, 8'h07);
        // Bit 6 forces frequency lock, even across a new reference
        wr(A_CTRL, 8'h54);
        wait_mode(CAP_FREQ, 4);
        new_ref();
        repeat (4) @(posedge clk_i);
        `CHK(capture_mode_o, CAP_FREQ)
        wr(A_CTRL, CTRL_RESET);
        // Clearing bit 6 inside the window hands back nearest-edge capture
        wait_mode(CAP_NEAREST, 4);
        wait_mode(CAP_WIDE, 16);
        // Bits 5 and 7 cannot be written; test bits 3,1,0 kept at zero
        wr(A_CTRL, 8'hf4);
        rd(A_CTRL, 8'h54);
        wr(A_CTRL, 8'h10);
        rd(A_CTRL, 8'h10);
        repeat (2) @(posedge clk_i);
        `CHK(frame_edge_sense_o, 1'b0)
        end_of_test();
    end

endmodule : lock_regs_test

`default_nettype wire
